// >>> verilog/clk_gate_pkg.sv
package clk_gate_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0]  ADDR_DIVIDER     = 4'h0;
  localparam logic [3:0]  ADDR_GATE        = 4'h4;
  localparam logic [3:0]  ADDR_PRESENT     = 4'h8;
  localparam logic [3:0]  ADDR_STATUS      = 4'hC;

  // ****************************************
  // divider control fields
  // ****************************************
  localparam int          DOZE_EN_BIT      = 11;
  localparam int          RATIO_LO         = 12;
  localparam int          RATIO_HI         = 14;
  localparam int          ROI_BIT          = 15;
  localparam logic [2:0]  RATIO_RESET      = 3'h0;
  localparam logic [15:0] DIVIDER_MASK     = 16'hF800;

  // ****************************************
  // gating register fields
  // ****************************************
  localparam int          NUM_PERIPH       = 10;
  localparam logic [15:0] GATE_MASK        = 16'hFAA9;
  localparam logic [15:0] GATE_RESET       = 16'h0000;
  localparam logic [15:0] PRESENT_DEFAULT  = 16'hFAA9;
  // bit position of each peripheral gate, index 0..9:
  // adc, spi, uart, i2c, pwm, timer1..timer5
  localparam int          GATE_POS [NUM_PERIPH] = '{0, 3, 5, 7, 9, 11, 12, 13, 14, 15};

  localparam int          DIV_CNT_W        = 7;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage

// >>> verilog/clk_gate.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module clk_gate
  import clk_gate_pkg::*;
(
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  NRST_I,
  input  wire logic                  IRQ_I,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_WR_I,
  input  wire logic [3:0]            S_AXI_AWADDR_I,
  input  wire logic                  S_AXI_AWVALID_I,
  output logic                       S_AXI_AWREADY_O,
  input  wire logic [31:0]           S_AXI_WDATA_I,
  input  wire logic [3:0]            S_AXI_WSTRB_I,
  input  wire logic                  S_AXI_WVALID_I,
  output logic                       S_AXI_WREADY_O,
  output logic [1:0]                 S_AXI_BRESP_O,
  output logic                       S_AXI_BVALID_O,
  input  wire logic                  S_AXI_BREADY_I,
  input  wire logic [3:0]            S_AXI_ARADDR_I,
  input  wire logic                  S_AXI_ARVALID_I,
  output logic                       S_AXI_ARREADY_O,
  output logic [31:0]                S_AXI_RDATA_O,
  output logic [1:0]                 S_AXI_RRESP_O,
  output logic                       S_AXI_RVALID_O,
  input  wire logic                  S_AXI_RREADY_I,
  output logic                       CORE_CLK_EN_O,
  output logic [NUM_PERIPH-1:0]      PERIPH_CLK_EN_O,
  output logic [NUM_PERIPH-1:0]      PERIPH_WR_EN_O
);

  // ****************************************
  // reset synchroniser
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic [15:0] divider_ctl;
  logic [15:0] gate_reg;
  logic [15:0] present;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_lo;
  logic        wr_hi;

  assign do_write = aw_held && w_held && !S_AXI_BVALID_O;
  assign wr_lo    = do_write && w_strb[0];
  assign wr_hi    = do_write && w_strb[1];

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_held         <= 1'b0;
      aw_addr         <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O && !S_AXI_BVALID_O;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      S_AXI_WREADY_O <= 1'b0;
    end else begin
      S_AXI_WREADY_O <= !w_held && !S_AXI_WREADY_O && !S_AXI_BVALID_O;
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= (aw_addr == ADDR_DIVIDER || aw_addr == ADDR_GATE ||
                         aw_addr == ADDR_PRESENT || aw_addr == ADDR_STATUS) ?
                        RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ****************************************
  // doze control register
  // ****************************************
  logic        irq_restore;
  assign irq_restore = IRQ_I && divider_ctl[ROI_BIT];

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      divider_ctl <= {1'b0, RATIO_RESET, 12'h000};
    end else begin
      if (do_write && aw_addr == ADDR_DIVIDER) begin
        if (wr_lo)
          divider_ctl[7:0] <= w_data[7:0] & DIVIDER_MASK[7:0];
        if (wr_hi)
          divider_ctl[15:8] <= w_data[15:8] & DIVIDER_MASK[15:8];
      end
      if (irq_restore)
        divider_ctl[DOZE_EN_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // gating and presence registers
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg <= GATE_RESET;
    end else if (do_write && aw_addr == ADDR_GATE) begin
      if (wr_lo)
        gate_reg[7:0] <= w_data[7:0] & GATE_MASK[7:0];
      if (wr_hi)
        gate_reg[15:8] <= w_data[15:8] & GATE_MASK[15:8];
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      present <= PRESENT_DEFAULT;
    end else if (do_write && aw_addr == ADDR_PRESENT) begin
      if (wr_lo)
        present[7:0] <= w_data[7:0] & GATE_MASK[7:0];
      if (wr_hi)
        present[15:8] <= w_data[15:8] & GATE_MASK[15:8];
    end
  end

  // ****************************************
  // core clock divider
  // ****************************************
  logic [DIV_CNT_W-1:0] div_cnt;
  logic [DIV_CNT_W-1:0] div_limit;
  logic                 dozing;
  logic                 next_core_en;

  assign dozing    = divider_ctl[DOZE_EN_BIT] && !irq_restore;
  assign div_limit = DIV_CNT_W'((8'h01 << divider_ctl[RATIO_HI:RATIO_LO]) - 8'h01);

  always_comb begin
    next_core_en = 1'b1;
    if (dozing)
      next_core_en = (div_cnt >= div_limit);
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt       <= '0;
      CORE_CLK_EN_O <= 1'b0;
    end else begin
      CORE_CLK_EN_O <= next_core_en;
      if (!dozing || div_cnt >= div_limit)
        div_cnt <= '0;
      else
        div_cnt <= div_cnt + 1'b1;
    end
  end

  // ****************************************
  // per-peripheral enables
  // ****************************************
  for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
    logic on;
    assign on = !gate_reg[GATE_POS[i]] && present[GATE_POS[i]];

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
        PERIPH_CLK_EN_O[i] <= 1'b0;
        PERIPH_WR_EN_O[i]  <= 1'b0;
      end else begin
        PERIPH_CLK_EN_O[i] <= on;
        PERIPH_WR_EN_O[i]  <= on && PERIPH_WR_I[i];
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [15:0] periph_status;
  for (genvar j = 0; j < 16; j++) begin : g_stat
    logic hit;
    always_comb begin
      hit = 1'b0;
      for (int k = 0; k < NUM_PERIPH; k++)
        if (GATE_POS[k] == j && PERIPH_CLK_EN_O[k])
          hit = 1'b1;
    end
    assign periph_status[j] = hit;
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= 32'h0000_0000;
      S_AXI_RRESP_O   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O  <= RESP_OKAY;
        case (S_AXI_ARADDR_I)
          ADDR_DIVIDER: S_AXI_RDATA_O <= {16'h0000, divider_ctl};
          ADDR_GATE:    S_AXI_RDATA_O <= {16'h0000, gate_reg};
          ADDR_PRESENT: S_AXI_RDATA_O <= {16'h0000, present};
          ADDR_STATUS:  S_AXI_RDATA_O <= {16'h0000, periph_status};
          default: begin
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_gate_off_next: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    gate_reg[GATE_POS[0]] |=> !PERIPH_CLK_EN_O[0])
    else $error("adc enable not dropped after gate bit");
  a_full_rate_idle: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    !divider_ctl[DOZE_EN_BIT] |=> CORE_CLK_EN_O)
    else $error("core slowed without slowdown bit");
  a_unused_zero: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (gate_reg & ~GATE_MASK) == 16'h0000)
    else $error("unused gate bit set");
  sequence s_full_speed_back;
    !divider_ctl[DOZE_EN_BIT] ##1 CORE_CLK_EN_O;
  endsequence
  a_roi_restore: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    irq_restore |=> s_full_speed_back)
    else $error("interrupt did not restore full speed");
  a_no_roi_keep: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (IRQ_I && !divider_ctl[ROI_BIT] && divider_ctl[DOZE_EN_BIT] && !do_write)
      |=> divider_ctl[DOZE_EN_BIT])
    else $error("interrupt changed slowdown");
  a_div_by_two: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (dozing && divider_ctl[RATIO_HI:RATIO_LO] == 3'h1 && CORE_CLK_EN_O)[*2] |-> 1'b0)
    else $error("ratio two gave back to back core enables");
  a_absent_off: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    !present[GATE_POS[5]] |=> !PERIPH_CLK_EN_O[5])
    else $error("absent timer enabled");
  a_gate_on_next: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    (!gate_reg[GATE_POS[9]] && present[GATE_POS[9]]) |=> PERIPH_CLK_EN_O[9])
    else $error("timer five enable not restored after gate bit cleared");
  a_wr_blocked: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    PERIPH_WR_EN_O[3] |-> $past(!gate_reg[GATE_POS[3]] && PERIPH_WR_I[3]))
    else $error("write passed to gated i2c");

endmodule

// >>> testbench/core_model.sv
`timescale 1ns/1ps
module core_model
  import clk_gate_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  core_en_i,
  input  wire logic                  clr_i,
  input  wire logic [NUM_PERIPH-1:0] req_i,
  output logic      [NUM_PERIPH-1:0] wr_o = '0,
  output int                         ticks_o
);
  // core write requests, count of core clock ticks
  always @(posedge clk_i) begin
    wr_o <= req_i;
    ticks_o <= clr_i ? 0 : ticks_o + int'(core_en_i);
  end
endmodule

// >>> testbench/clk_gate_tb.sv
`timescale 1ns/1ps
module clk_gate_tb
  import clk_gate_pkg::*;
;
  logic                  clk = 1'h0, nrst = 1'h0, irq = 1'h0, clr = 1'h0;
  logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                  arvalid = 1'h0, rready = 1'h0;
  logic                  awready, wready, bvalid, arready, rvalid, core_en;
  logic [3:0]            awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]           wdata = 32'h0000_0000, rdata, d;
  logic [1:0]            bresp, rresp, resp;
  logic [NUM_PERIPH-1:0] req = '0, wr, pclk_en, pwr_en;
  int                    ticks, fails = 0, checked = 0;

  always #4 clk = ~clk;

  clk_gate clk_gate_inst (
    .CLK_SYS_I(clk), .NRST_I(nrst), .IRQ_I(irq), .PERIPH_WR_I(wr),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .CORE_CLK_EN_O(core_en),
    .PERIPH_CLK_EN_O(pclk_en), .PERIPH_WR_EN_O(pwr_en)
  );
  core_model core_model_inst (
    .clk_i(clk), .core_en_i(core_en), .clr_i(clr), .req_i(req), .wr_o(wr),
    .ticks_o(ticks)
  );

  // ****
  // bus and check helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge clk);
    chk(nm, e, d);
  endtask

  // settle, then count core ticks over 256 cycles
  task automatic cnt(input int e);
    repeat (130) @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (257) @(posedge clk);
    chk("core ticks", e, ticks);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd("divider", ADDR_DIVIDER, 32'h0000_0000);
    rd("gate", ADDR_GATE, 32'h0000_0000);
    rd("present", ADDR_PRESENT, 32'h0000_FAA9);
    rd("status", ADDR_STATUS, 32'h0000_FAA9);
    chk("clk en", 32'h0000_03FF, pclk_en);
    chk("core en", 32'h0000_0001, core_en);
    rd("unmapped", 4'h2, 32'h0000_0000);
    chk("rresp", RESP_SLVERR, resp);
    wr_reg(4'h2, 16'hFFFF);
    chk("bresp", RESP_SLVERR, resp);
    rd("divider kept", ADDR_DIVIDER, 32'h0000_0000);
  endtask

  task automatic t_gates;
    for (int i = 0; i < NUM_PERIPH; i++) begin
      wr_reg(ADDR_GATE, 16'h0001 << GATE_POS[i]);
      chk("one off", {22'h00_0000, ~(10'h001 << i)}, pclk_en);
    end
    wr_reg(ADDR_GATE, 16'hFFFF);
    rd("gate mask", ADDR_GATE, 32'h0000_FAA9);
    chk("all off", 32'h0000_0000, pclk_en);
    rd("status off", ADDR_STATUS, 32'h0000_0000);
    req <= 10'h3FF;
    repeat (3) @(posedge clk);
    chk("wr blocked", 32'h0000_0000, pwr_en);
    wr_reg(ADDR_GATE, 16'h0080);
    chk("wr i2c off", 32'h0000_03F7, pwr_en);
    wr_reg(ADDR_GATE, 16'h0000);
    chk("all on", 32'h0000_03FF, pclk_en);
    chk("wr passed", 32'h0000_03FF, pwr_en);
    req <= 10'h000;
  endtask

  task automatic t_present;
    wr_reg(ADDR_PRESENT, 16'h0001);
    chk("bresp ok", RESP_OKAY, resp);
    chk("absent off", 32'h0000_0001, pclk_en);
    wr_reg(ADDR_PRESENT, 16'hFAA9);
  endtask

  task automatic t_doze;
    for (int n = 0; n < 8; n++) begin
      wr_reg(ADDR_DIVIDER, 16'h0800 | (16'(n) << 12));
      cnt(256 >> n);
      chk("periph full", 32'h0000_03FF, pclk_en);
    end
    wr_reg(ADDR_DIVIDER, 16'h7000);
    cnt(256);
  endtask

  task automatic t_irq;
    wr_reg(ADDR_DIVIDER, 16'h3800);
    irq <= 1'h1;
    @(posedge clk);
    irq <= 1'h0;
    cnt(32);
    rd("no return", ADDR_DIVIDER, 32'h0000_3800);
    wr_reg(ADDR_DIVIDER, 16'hB800);
    irq <= 1'h1;
    @(posedge clk);
    irq <= 1'h0;
    rd("return", ADDR_DIVIDER, 32'h0000_B000);
    cnt(256);
  endtask

  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    repeat (5) @(posedge clk);
    t_reset();
    t_gates();
    t_present();
    t_doze();
    t_irq();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule
